// ===== core/coder_pkg.sv
// shared constants and types for the 100 Mb/s symbol coder
package coder_pkg;
   localparam int          SYM_W      = 5;
   localparam logic [2:0]  SYM_LAST   = 3'h4;
   localparam logic [2:0]  SYM_FIRST  = 3'h0;
   localparam int          LFSR_W     = 11;
   localparam int          TAP_HI     = 10;
   localparam int          TAP_LO     = 8;
   localparam logic [10:0] LFSR_SEED  = 11'h7ff;
   localparam logic [7:0]  LOCK_COUNT = 8'h3c;
   localparam logic [7:0]  HIT_ZERO   = 8'h00;
   localparam logic [7:0]  HIT_ONE    = 8'h01;

   // control symbols
   localparam logic [4:0] SYM_IDLE  = 5'h1f;
   localparam logic [4:0] SYM_J     = 5'h18;
   localparam logic [4:0] SYM_K     = 5'h11;
   localparam logic [4:0] SYM_T     = 5'h0d;
   localparam logic [4:0] SYM_R     = 5'h07;
   localparam logic [4:0] SYM_H     = 5'h04;
   localparam logic [3:0] NIB_START = 4'h5;
   localparam logic [3:0] NIB_ZERO  = 4'h0;

   // three-level line codes
   localparam logic [1:0] LVL_LOW  = 2'h0;
   localparam logic [1:0] LVL_MID  = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_START = 2'b01,
      TX_DATA  = 2'b10,
      TX_END   = 2'b11
   } tx_state_t;

   typedef enum logic [2:0] {
      K_DATA    = 3'b000,
      K_IDLE    = 3'b001,
      K_START_J = 3'b010,
      K_START_K = 3'b011,
      K_END_T   = 3'b100,
      K_END_R   = 3'b101,
      K_ERROR   = 3'b110,
      K_INVALID = 3'b111
   } sym_kind_t;
endpackage : coder_pkg

// ===== core/scramble_lfsr.sv
// key stream generator for scrambling and descrambling
`timescale 1ns/1ps
`default_nettype none
module scramble_lfsr #(
   parameter int          WIDTH = coder_pkg::LFSR_W,
   parameter logic [10:0] SEED  = coder_pkg::LFSR_SEED
) (
   input  wire logic CLOCK_IN,
   input  wire logic RST_B_IN,
   input  wire logic SEED_EN_IN,
   input  wire logic SEED_BIT_IN,
   output logic      KEY_OUT
);
   import coder_pkg::*;

   logic [WIDTH-1:0] state;
   logic [WIDTH-1:0] next_state;

   assign KEY_OUT = state[TAP_HI] ^ state[TAP_LO];

   always_comb begin
      next_state = {state[WIDTH-2:0], SEED_EN_IN ? SEED_BIT_IN : KEY_OUT};
   end

   always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         state <= SEED[WIDTH-1:0];
      end else begin
         state <= next_state;
      end
   end
endmodule // scramble_lfsr
`default_nettype wire

// ===== core/tx_4b5b_nrzi_mlt3_coder.sv
// 4b5b, scrambler, nrzi and three-level coder with matching receive path
// Operation
// - data nibbles map to fixed 5-bit symbols and back.
// - a frame opens with the start pair, recognised on receive as start.
// - a frame closes with the end pair, recognised on receive as end.
// - idle fills gaps between frames and a MAC error sends the error code.
// - the ten unused patterns are flagged on receive and never sent.
// - the nrzi stage toggles on each one bit and holds on each zero.
// - the line state has three levels, stepping one level per transition.
// - the levels cycle low, middle, high, middle, low.
// - the serial stream is scrambled before line coding, descrambled after.
`timescale 1ns/1ps
`default_nettype none
module tx_4b5b_nrzi_mlt3_coder (
   input  wire logic CLOCK_IN,
   input  wire logic RST_B_IN,
   input  wire logic TX_EN_IN,
   input  wire logic TX_ER_IN,
   input  wire logic [3:0] TXD_IN,
   output logic      TX_NIBBLE_REQ_OUT,
   output logic      TX_NRZI_OUT,
   output logic [1:0] TX_LEVEL_OUT,
   input  wire logic [1:0] RX_LEVEL_IN,
   output logic      RX_LOCKED_OUT,
   output logic      RX_DV_OUT,
   output logic      RX_VALID_OUT,
   output logic [3:0] RXD_OUT,
   output logic      RX_ER_OUT,
   output logic      RX_START_OUT,
   output logic      RX_END_OUT
);
   import coder_pkg::*;

   function automatic logic [4:0] encode(input logic [3:0] nib);
      logic [4:0] s;
      s = SYM_IDLE;
      unique case (nib)
         4'h0: s = 5'h1e;
         4'h1: s = 5'h09;
         4'h2: s = 5'h14;
         4'h3: s = 5'h15;
         4'h4: s = 5'h0a;
         4'h5: s = 5'h0b;
         4'h6: s = 5'h0e;
         4'h7: s = 5'h0f;
         4'h8: s = 5'h12;
         4'h9: s = 5'h13;
         4'ha: s = 5'h16;
         4'hb: s = 5'h17;
         4'hc: s = 5'h1a;
         4'hd: s = 5'h1b;
         4'he: s = 5'h1c;
         4'hf: s = 5'h1d;
      endcase
      return s;
   endfunction

   function automatic sym_kind_t classify(input logic [4:0] s);
      sym_kind_t k;
      k = K_DATA;
      unique case (s)
         SYM_IDLE: k = K_IDLE;
         SYM_J:    k = K_START_J;
         SYM_K:    k = K_START_K;
         SYM_T:    k = K_END_T;
         SYM_R:    k = K_END_R;
         SYM_H:    k = K_ERROR;
         5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
         5'h06, 5'h08, 5'h0c, 5'h10, 5'h19: k = K_INVALID;
         default:  k = K_DATA;
      endcase
      return k;
   endfunction

   function automatic logic [3:0] decode(input logic [4:0] s);
      logic [3:0] n;
      n = NIB_ZERO;
      for (int i = 0; i < 16; i++) begin
         if (encode(i[3:0]) == s) begin
            n = i[3:0];
         end
      end
      return n;
   endfunction

   // ---------------- transmit ----------------
   tx_state_t  tx_state, next_tx_state;
   logic [4:0] tx_sym, next_tx_sym;
   logic [2:0] tx_cnt, next_tx_cnt;
   logic       tx_key;
   logic       tx_scr;
   logic       nrzi, next_nrzi;
   logic [1:0] level, next_level;
   logic       rising, next_rising;
   logic       tx_load;

   assign tx_load           = (tx_cnt == SYM_LAST);
   assign TX_NIBBLE_REQ_OUT = tx_load;
   assign tx_scr            = tx_sym[SYM_W-1] ^ tx_key;

   scramble_lfsr #(
      .WIDTH (LFSR_W),
      .SEED  (LFSR_SEED)
   ) u_tx_lfsr (
      .CLOCK_IN    (CLOCK_IN),
      .RST_B_IN    (RST_B_IN),
      .SEED_EN_IN  (1'b0),
      .SEED_BIT_IN (1'b0),
      .KEY_OUT     (tx_key)
   );

   always_comb begin
      next_tx_state = tx_state;
      next_tx_cnt   = tx_load ? SYM_FIRST : tx_cnt + 3'h1;
      next_tx_sym   = {tx_sym[SYM_W-2:0], 1'b0};
      if (tx_load) begin
         unique case (tx_state)
            TX_IDLE: begin
               next_tx_sym = SYM_IDLE;
               if (TX_EN_IN) begin
                  next_tx_sym   = SYM_J;
                  next_tx_state = TX_START;
               end
            end
            TX_START: begin
               next_tx_sym   = SYM_K;
               next_tx_state = TX_DATA;
            end
            TX_DATA: begin
               if (!TX_EN_IN) begin
                  next_tx_sym   = SYM_T;
                  next_tx_state = TX_END;
               end else if (TX_ER_IN) begin
                  next_tx_sym = SYM_H;
               end else begin
                  next_tx_sym = encode(TXD_IN);
               end
            end
            TX_END: begin
               next_tx_sym   = SYM_R;
               next_tx_state = TX_IDLE;
            end
         endcase
      end
      next_nrzi   = nrzi ^ tx_scr;
      next_level  = level;
      next_rising = rising;
      if (tx_scr) begin
         unique case (level)
            LVL_LOW: begin
               next_level  = LVL_MID;
               next_rising = 1'b1;
            end
            LVL_HIGH: begin
               next_level  = LVL_MID;
               next_rising = 1'b0;
            end
            default: begin
               next_level = rising ? LVL_HIGH : LVL_LOW;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         tx_state <= TX_IDLE;
         tx_sym   <= SYM_IDLE;
         tx_cnt   <= SYM_FIRST;
         nrzi     <= 1'b0;
         level    <= LVL_MID;
         rising   <= 1'b1;
      end else begin
         tx_state <= next_tx_state;
         tx_sym   <= next_tx_sym;
         tx_cnt   <= next_tx_cnt;
         nrzi     <= next_nrzi;
         level    <= next_level;
         rising   <= next_rising;
      end
   end

   assign TX_NRZI_OUT  = nrzi;
   assign TX_LEVEL_OUT = level;

   // ---------------- receive ----------------
   logic [1:0] rx_prev;
   logic       rx_raw, rx_key, rx_bit;
   logic [7:0] hits, next_hits;
   logic       locked, next_locked;
   logic [9:0] hist, next_hist;
   logic [2:0] rx_cnt, next_rx_cnt;
   logic       in_frame, next_in_frame;
   logic       saw_t, next_saw_t;
   logic       valid, next_valid;
   logic [3:0] rxd, next_rxd;
   logic       err, next_err;
   logic       start, next_start;
   logic       fend, next_fend;
   sym_kind_t  kind;

   // a level change is an nrzi transition, hence a one
   assign rx_raw = (RX_LEVEL_IN != rx_prev);
   assign rx_bit = rx_raw ^ rx_key;
   assign kind   = classify(next_hist[4:0]);

   scramble_lfsr #(
      .WIDTH (LFSR_W),
      .SEED  (LFSR_SEED)
   ) u_rx_lfsr (
      .CLOCK_IN    (CLOCK_IN),
      .RST_B_IN    (RST_B_IN),
      .SEED_EN_IN  (!locked),
      .SEED_BIT_IN (!rx_raw),
      .KEY_OUT     (rx_key)
   );

   always_comb begin
      next_hits     = hits;
      next_locked   = locked;
      next_hist     = {hist[8:0], rx_bit};
      next_rx_cnt   = (rx_cnt == SYM_LAST) ? SYM_FIRST : rx_cnt + 3'h1;
      next_in_frame = in_frame;
      next_saw_t    = saw_t;
      next_valid    = 1'b0;
      next_rxd      = rxd;
      next_err      = 1'b0;
      next_start    = 1'b0;
      next_fend     = 1'b0;
      if (!locked) begin
         // lock after a run of predicted idle ones
         next_hits = rx_bit ? hits + HIT_ONE : HIT_ZERO;
         if (hits == LOCK_COUNT) begin
            next_locked = 1'b1;
         end
      end else if (!in_frame) begin
         if (next_hist == {SYM_J, SYM_K}) begin
            next_in_frame = 1'b1;
            next_rx_cnt   = SYM_FIRST;
            next_saw_t    = 1'b0;
            next_start    = 1'b1;
         end
      end else if (rx_cnt == SYM_LAST) begin
         next_saw_t = 1'b0;
         unique case (kind)
            K_DATA: begin
               next_valid = 1'b1;
               next_rxd   = decode(next_hist[4:0]);
            end
            K_END_T: begin
               next_saw_t = 1'b1;
            end
            K_END_R: begin
               next_in_frame = 1'b0;
               next_fend     = 1'b1;
               next_err      = !saw_t;
            end
            K_IDLE: begin
               next_in_frame = 1'b0;
               next_fend     = 1'b1;
               next_err      = 1'b1;
            end
            default: begin
               next_valid = 1'b1;
               next_err   = 1'b1;
               next_rxd   = NIB_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rx_prev  <= LVL_MID;
         hits     <= HIT_ZERO;
         locked   <= 1'b0;
         hist     <= {SYM_IDLE, SYM_IDLE};
         rx_cnt   <= SYM_FIRST;
         in_frame <= 1'b0;
         saw_t    <= 1'b0;
         valid    <= 1'b0;
         rxd      <= NIB_ZERO;
         err      <= 1'b0;
         start    <= 1'b0;
         fend     <= 1'b0;
      end else begin
         rx_prev  <= RX_LEVEL_IN;
         hits     <= next_hits;
         locked   <= next_locked;
         hist     <= next_hist;
         rx_cnt   <= next_rx_cnt;
         in_frame <= next_in_frame;
         saw_t    <= next_saw_t;
         valid    <= next_valid;
         rxd      <= next_rxd;
         err      <= next_err;
         start    <= next_start;
         fend     <= next_fend;
      end
   end

   assign RX_LOCKED_OUT = locked;
   assign RX_DV_OUT     = in_frame;
   assign RX_VALID_OUT  = valid;
   assign RXD_OUT       = rxd;
   assign RX_ER_OUT     = err;
   assign RX_START_OUT  = start;
   assign RX_END_OUT    = fend;
endmodule // tx_4b5b_nrzi_mlt3_coder
`default_nettype wire

// ===== test/coder_checker.sv
// port assertions for the symbol coder
`timescale 1ns/1ps
`default_nettype none
module coder_checker
   import coder_pkg::*;
(
   input wire logic       CLOCK_IN,
   input wire logic       RST_B_IN,
   input wire logic       TX_EN_IN,
   input wire logic       TX_ER_IN,
   input wire logic [3:0] TXD_IN,
   input wire logic       TX_NIBBLE_REQ_OUT,
   input wire logic       TX_NRZI_OUT,
   input wire logic [1:0] TX_LEVEL_OUT,
   input wire logic [1:0] RX_LEVEL_IN,
   input wire logic       RX_LOCKED_OUT,
   input wire logic       RX_DV_OUT,
   input wire logic       RX_VALID_OUT,
   input wire logic [3:0] RXD_OUT,
   input wire logic       RX_ER_OUT,
   input wire logic       RX_START_OUT,
   input wire logic       RX_END_OUT
);
   logic [1:0] last_ext;
   logic [1:0] next_last_ext;
   always_comb begin
      next_last_ext = last_ext;
      if (TX_LEVEL_OUT != LVL_MID) next_last_ext = TX_LEVEL_OUT;
   end
   always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) last_ext <= LVL_LOW;
      else last_ext <= next_last_ext;
   end
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_B_IN);
   a_req_every_five: assert property (TX_NIBBLE_REQ_OUT |=>
      !TX_NIBBLE_REQ_OUT [*4] ##1 TX_NIBBLE_REQ_OUT) else $error("req spacing");
   a_level_one_step: assert property ($changed(TX_LEVEL_OUT) |->
      TX_LEVEL_OUT == LVL_MID || $past(TX_LEVEL_OUT) == LVL_MID)
      else $error("level jumped");
   a_level_legal: assert property (TX_LEVEL_OUT != 2'h3)
      else $error("bad level code");
   a_level_cycle_order: assert property ($changed(TX_LEVEL_OUT) &&
      TX_LEVEL_OUT != LVL_MID |-> TX_LEVEL_OUT != last_ext)
      else $error("level order");
   a_nrzi_with_level: assert property ($changed(TX_NRZI_OUT) ==
      $changed(TX_LEVEL_OUT)) else $error("nrzi and level apart");
   a_valid_spacing: assert property (RX_VALID_OUT |=>
      !RX_VALID_OUT [*4]) else $error("results too close");
   a_start_opens_frame: assert property (RX_START_OUT |->
      $rose(RX_DV_OUT)) else $error("start without frame");
   a_end_closes_frame: assert property (RX_END_OUT |->
      ##[0:1] !RX_DV_OUT) else $error("frame left open");
   a_frame_needs_lock: assert property (!RX_LOCKED_OUT |->
      !RX_DV_OUT && !RX_VALID_OUT) else $error("decode before lock");
   a_lock_holds: assert property (RX_LOCKED_OUT |=> RX_LOCKED_OUT)
      else $error("lock dropped");
   a_error_qualified: assert property (RX_ER_OUT |->
      RX_VALID_OUT || RX_END_OUT) else $error("stray error");
endmodule // coder_checker
bind tx_4b5b_nrzi_mlt3_coder coder_checker chk_u (.CLOCK_IN, .RST_B_IN,
   .TX_EN_IN, .TX_ER_IN, .TXD_IN, .TX_NIBBLE_REQ_OUT, .TX_NRZI_OUT,
   .TX_LEVEL_OUT, .RX_LEVEL_IN, .RX_LOCKED_OUT, .RX_DV_OUT, .RX_VALID_OUT,
   .RXD_OUT, .RX_ER_OUT, .RX_START_OUT, .RX_END_OUT);
`default_nettype wire

// ===== test/line_far_end.sv
// far line end: relays line, can force descrambled bits
`timescale 1ns/1ps
`default_nettype none
module line_far_end
   import coder_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       rst_b_in,
   input  wire logic [1:0] line_in,
   input  wire logic [1:0] force_in,
   output logic      [1:0] line_out
);
   logic [1:0]  prev, next_prev, next_line;
   logic [10:0] key_s, next_key_s;
   logic [6:0]  sync, next_sync;
   logic        rise, next_rise, raw, key, bit_out;
   always_comb begin
      raw = line_in != prev;
      key = key_s[10] ^ key_s[8];
      bit_out = (force_in == 2'h0) ? raw : (force_in[1] ^ key);
      next_prev = line_in;
      next_sync = sync;
      // self-lock on idle then run free
      if (sync != 7'h7f) begin
         next_sync = sync + 7'h01;
         next_key_s = {key_s[9:0], ~raw};
      end else next_key_s = {key_s[9:0], key};
      next_rise = rise;
      next_line = line_out;
      // one level step per one bit
      if (bit_out) begin
         if (line_out == LVL_MID) next_line = rise ? LVL_HIGH : LVL_LOW;
         else begin
            next_line = LVL_MID;
            next_rise = (line_out == LVL_LOW);
         end
      end
   end
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prev <= LVL_MID;
         key_s <= LFSR_SEED;
         sync <= 7'h00;
         rise <= 1'b1;
         line_out <= LVL_MID;
      end else begin
         prev <= next_prev;
         key_s <= next_key_s;
         sync <= next_sync;
         rise <= next_rise;
         line_out <= next_line;
      end
   end
endmodule // line_far_end
`default_nettype wire

// ===== test/tx_4b5b_nrzi_mlt3_coder_bench.sv
// self-checking bench for the symbol coder
`timescale 1ns/1ps
`default_nettype none
module tx_4b5b_nrzi_mlt3_coder_bench;
   import coder_pkg::*;
   typedef struct packed {
      logic       er;
      logic [3:0] d;
      logic       er_x;
      logic [3:0] d_x;
   } row_t;
   logic       clock, rst_b, tx_en, tx_er, req, nrzi, locked, dv, valid;
   logic       rx_er, start, fin;
   logic [3:0] txd, rxd;
   logic [1:0] tx_level, rx_level, force_mode;
   int         bad_count, num_checks, n_start, n_end, n_end_er, n_er, e0;
   row_t       rows[17];
   logic [4:0] got[$];
   tx_4b5b_nrzi_mlt3_coder dut_u (.CLOCK_IN(clock), .RST_B_IN(rst_b),
      .TX_EN_IN(tx_en), .TX_ER_IN(tx_er), .TXD_IN(txd),
      .TX_NIBBLE_REQ_OUT(req), .TX_NRZI_OUT(nrzi), .TX_LEVEL_OUT(tx_level),
      .RX_LEVEL_IN(rx_level), .RX_LOCKED_OUT(locked), .RX_DV_OUT(dv),
      .RX_VALID_OUT(valid), .RXD_OUT(rxd), .RX_ER_OUT(rx_er),
      .RX_START_OUT(start), .RX_END_OUT(fin));
   line_far_end far_u (.clock_in(clock), .rst_b_in(rst_b),
      .line_in(tx_level), .force_in(force_mode), .line_out(rx_level));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(negedge clock) begin
      if (valid === 1'b1) got.push_back({rx_er, rxd});
      if (start === 1'b1) n_start++;
      if (fin === 1'b1) n_end++;
      if (fin === 1'b1 && rx_er === 1'b1) n_end_er++;
   end
   task automatic check(input string name, input logic [4:0] exp,
                        input logic [4:0] seen);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic send(input logic en, input logic er, input logic [3:0] d);
      for (int n = 0; n < 20 && req !== 1'b1; n++) @(negedge clock);
      check("nibble request", 5'h01, {4'h0, req});
      tx_en = en;
      tx_er = er;
      txd = d;
      @(negedge clock);
   endtask
   task automatic corrupt_frame(input logic [1:0] mode);
      got.delete();
      send(1'b1, 1'b0, NIB_START);
      send(1'b1, 1'b0, NIB_START);
      for (int i = 0; i < 4; i++) send(1'b1, 1'b0, NIB_ZERO);
      force_mode = mode;
      repeat (10) @(negedge clock);
      force_mode = 2'h0;
      for (int i = 0; i < 4; i++) send(1'b1, 1'b0, NIB_ZERO);
      send(1'b0, 1'b0, NIB_ZERO);
      repeat (40) @(negedge clock);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      report_and_stop;
   end
   initial begin
      {rst_b, tx_en, tx_er, txd, force_mode} = 9'h000;
      for (int i = 0; i < 16; i++) rows[i] = {1'b0, 4'(i), 1'b0, 4'(i)};
      rows[16] = {1'b1, 4'h9, 1'b1, NIB_ZERO};
      repeat (8) @(negedge clock);
      check("reset level", {3'h0, LVL_MID}, {3'h0, tx_level});
      check("reset nrzi", 5'h00, {4'h0, nrzi});
      check("reset rx", 5'h00, {locked, dv, valid, start, fin});
      rst_b = 1'b1;
      for (int n = 0; n < 300 && locked !== 1'b1; n++) @(negedge clock);
      check("lock", 5'h01, {4'h0, locked});
      repeat (100) @(negedge clock);
      send(1'b1, 1'b0, NIB_START);
      send(1'b1, 1'b0, NIB_START);
      foreach (rows[i]) send(1'b1, rows[i].er, rows[i].d);
      send(1'b0, 1'b0, NIB_ZERO);
      repeat (40) @(negedge clock);
      check("result count", 5'h11, 5'(got.size()));
      foreach (rows[i])
         check("rx symbol", {rows[i].er_x, rows[i].d_x}, got[i]);
      check("start count", 5'h01, 5'(n_start));
      check("clean end", 5'h01, 5'(n_end - n_end_er));
      corrupt_frame(2'h1);
      n_er = 0;
      foreach (got[i]) if (got[i][4]) n_er++;
      check("invalid flagged", 5'h01, {4'h0, n_er > 0});
      e0 = n_end_er;
      corrupt_frame(2'h2);
      check("end on idle", 5'h01, 5'(n_end_er - e0));
      check("start count", 5'h03, 5'(n_start));
      report_and_stop;
   end
endmodule // tx_4b5b_nrzi_mlt3_coder_bench
`default_nettype wire
